// ---- hw/exec_pkg.sv ----
// package with opcodes, phases and address constants for the exec slice
package exec_pkg;
    // opcode patterns on instruction bits [15:8] (masked compares)
    localparam logic [5:0] OPC_INCR_SKIP_ZERO = 6'h0f;     // 0011 11
    localparam logic [5:0] OPC_INCR_SKIP_NONZERO = 6'h12;  // 0100 10
    localparam logic [7:0] OPC_MULT_LITERAL = 8'h0d;       // 0000 1101
    localparam logic [6:0] OPC_MULT_REGISTER = 7'h01;      // 0000 001
    localparam logic [7:0] OPC_BRANCH_NOT_ZERO = 8'he1;    // 1110 0001
    // field positions
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT_INCR = 8;
    localparam int BANK_BIT_MULT = 8;
    // indexed literal offset window limit
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    // reset values
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // phase codes, one-hot
    typedef enum logic [3:0] {
        PH_DECODE = 4'b0001,
        PH_READ = 4'b0010,
        PH_PROCESS = 4'b0100,
        PH_WRITE = 4'b1000
    } phase_t;
    // cycle kind, one-hot
    typedef enum logic [1:0] {
        CYC_EXEC = 2'b01,
        CYC_NOP = 2'b10
    } cycle_t;
endpackage

// ---- hw/exec_addr_gen.sv ----
// file address former: access bank, banked or indexed literal offset
module exec_addr_gen (
    // operand fields
    input wire logic [7:0] f_addr_i,
    input wire logic bank_bit_i,
    // context
    input wire logic [3:0] bank_sel_i,
    input wire logic ext_set_i,
    input wire logic [11:0] index_base_i,
    // address out
    output logic [11:0] addr_o
);
    // ------------------------------------------------------------
    // address selection
    // ------------------------------------------------------------
    wire logic indexed = !bank_bit_i && ext_set_i &&
        (f_addr_i <= exec_pkg::INDEXED_LIMIT);
    wire logic [11:0] idx_sum = index_base_i + {4'h0, f_addr_i};
    // access bank: low half in bank 0, upper half in bank f (sfr)
    wire logic [11:0] access_addr = f_addr_i[7] ?
        {4'hf, f_addr_i} : {4'h0, f_addr_i};
    wire logic [11:0] banked_addr = {bank_sel_i, f_addr_i};
    assign addr_o = indexed ? idx_sum :
        (bank_bit_i ? banked_addr : access_addr);
endmodule

// ---- hw/exec_mult.sv ----
// unsigned 8x8 multiplier, combinational, no flags produced
module exec_mult (
    // operands
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    // product
    output logic [15:0] prod_o
);
    // ------------------------------------------------------------
    // product
    // ------------------------------------------------------------
    // no zero, carry or overflow detection by design
    assign prod_o = {8'h00, a_i} * {8'h00, b_i};
endmodule

// ---- hw/incr_skip_multiply_branch_exec.sv ----
// execution slice: increment-skip, multiply and branch-if-not-zero
// What this block does
// - incr_skip_if_zero adds one to a file register and skips on zero.
// - incr_skip_if_nonzero decodes from 0100 10da and adds one to f.
// - incr_skip_if_nonzero skips the next instruction on a nonzero sum.
// - a skip costs one no-op cycle, two when a two-word one is skipped.
// - destination bit 0 writes the accumulator, 1 writes f back.
// - bank bit 0 picks the access bank, 1 the bank select register.
// - bank bit 0 with extended set makes f up to 95 an indexed offset.
// - multiply_by_literal stores acc times literal, high byte above.
// - multiply_by_literal decodes from 0000 1101 and takes one cycle.
// - multiply_by_literal leaves the accumulator and all flags alone.
// - a zero product is not flagged and no carry or overflow arises.
// - multiply_by_register decodes from 0000 001a, stores acc times f.
// - multiply_by_register keeps acc, f and flags and takes one cycle.
// - a taken branch loads pc in phase four then idles; untaken loads nothing.
// - branch_if_not_zero on a clear zero flag goes to pc + 2 + 2n.
module incr_skip_multiply_branch_exec #(
    parameter int PC_WIDTH = 21
) (
    // clock, reset, enable
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    // fetched instruction and context
    input wire logic [15:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    input wire logic NEXT_TWO_WORD_I,
    input wire logic [PC_WIDTH-1:0] PC_I,
    input wire logic [7:0] ACC_I,
    input wire logic [3:0] BANK_SEL_I,
    input wire logic ZERO_FLAG_I,
    input wire logic EXT_SET_I,
    input wire logic [11:0] INDEX_BASE_I,
    // file register read data
    input wire logic [7:0] FILE_RDATA_I,
    // file register access
    output logic [11:0] FILE_ADDR_O,
    output logic FILE_RD_O,
    output logic FILE_WR_O,
    output logic [7:0] FILE_WDATA_O,
    // accumulator write
    output logic ACC_WR_O,
    output logic [7:0] ACC_WDATA_O,
    // product register pair
    output logic PROD_WR_O,
    output logic [7:0] PROD_HIGH_O,
    output logic [7:0] PROD_LOW_O,
    // program counter load and pipeline control
    output logic PC_LOAD_O,
    output logic [PC_WIDTH-1:0] PC_NEXT_O,
    output logic FLUSH_O,
    output logic BUSY_O,
    output logic [3:0] PHASE_O
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic is_isz = INSTR_I[15:10] == exec_pkg::OPC_INCR_SKIP_ZERO;
    wire logic is_isnz =
        INSTR_I[15:10] == exec_pkg::OPC_INCR_SKIP_NONZERO;
    wire logic is_mlit = INSTR_I[15:8] == exec_pkg::OPC_MULT_LITERAL;
    wire logic is_mreg = INSTR_I[15:9] == exec_pkg::OPC_MULT_REGISTER;
    wire logic is_bnz = INSTR_I[15:8] == exec_pkg::OPC_BRANCH_NOT_ZERO;
    wire logic dest_file = INSTR_I[exec_pkg::DEST_BIT];
    wire logic bank_bit = INSTR_I[exec_pkg::BANK_BIT_INCR];
    wire logic [11:0] addr;
    wire logic [15:0] prod;

    exec_addr_gen u_addr (
        .f_addr_i(INSTR_I[7:0]),
        .bank_bit_i(bank_bit),
        .bank_sel_i(BANK_SEL_I),
        .ext_set_i(EXT_SET_I),
        .index_base_i(INDEX_BASE_I),
        .addr_o(addr)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    exec_pkg::phase_t phase_reg, phase_next;
    exec_pkg::cycle_t cyc_reg, cyc_next;
    logic [1:0] nop_left_reg, nop_left_next;
    logic [15:0] ir_reg;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic [15:0] prod_reg;
    logic [PC_WIDTH-1:0] pc_reg;
    logic zero_reg, two_word_reg;
    logic [11:0] addr_reg;
    logic isz_r, isnz_r, mlit_r, mreg_r, bnz_r, dest_r;

    wire logic incr_op = isz_r || isnz_r;
    wire logic [7:0] incr_val = operand_reg + 8'h01;
    // multiplier operand: literal for one form, file data for the other
    wire logic [7:0] mult_b = mlit_r ? ir_reg[7:0] : operand_reg;
    exec_mult u_mult (
        .a_i(ACC_I),
        .b_i(mult_b),
        .prod_o(prod)
    );
    // offset doubled and sign extended; pc_reg already points past us
    wire logic [PC_WIDTH-1:0] br_off =
        {{(PC_WIDTH-9){ir_reg[7]}}, ir_reg[7:0], 1'b0};
    wire logic [PC_WIDTH-1:0] br_target = pc_reg + br_off;
    wire logic taken = bnz_r && !zero_reg;
    wire logic res_zero = result_reg == exec_pkg::BYTE_RESET;
    wire logic do_skip = (isz_r && res_zero) ||
        (isnz_r && !res_zero);
    wire logic accept = INSTR_VALID_I && cyc_reg == exec_pkg::CYC_EXEC;

    // phase rotation: one-hot walk q1 to q4
    always_comb begin
        case (phase_reg)
            exec_pkg::PH_DECODE: phase_next = exec_pkg::PH_READ;
            exec_pkg::PH_READ: phase_next = exec_pkg::PH_PROCESS;
            exec_pkg::PH_PROCESS: phase_next = exec_pkg::PH_WRITE;
            exec_pkg::PH_WRITE: phase_next = exec_pkg::PH_DECODE;
            default: phase_next = exec_pkg::PH_DECODE;
        endcase
    end

    // cycle kind after phase four: nop cycles are queued by skips/branches
    always_comb begin
        cyc_next = cyc_reg;
        nop_left_next = nop_left_reg;
        if (phase_reg == exec_pkg::PH_WRITE) begin
            case (cyc_reg)
                exec_pkg::CYC_EXEC: begin
                    if (do_skip) begin
                        nop_left_next = two_word_reg ? 2'd1 : 2'd0;
                        cyc_next = exec_pkg::CYC_NOP;
                    end else if (taken) begin
                        nop_left_next = 2'd0;
                        cyc_next = exec_pkg::CYC_NOP;
                    end
                end
                exec_pkg::CYC_NOP: begin
                    if (nop_left_reg == 2'd0) begin
                        cyc_next = exec_pkg::CYC_EXEC;
                    end else begin
                        nop_left_next = nop_left_reg - 2'd1;
                    end
                end
                default: cyc_next = exec_pkg::CYC_EXEC;
            endcase
        end
    end

    // phase and cycle state
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            phase_reg <= exec_pkg::PH_DECODE;
            cyc_reg <= exec_pkg::CYC_EXEC;
            nop_left_reg <= 2'd0;
        end else if (CE_I) begin
            phase_reg <= phase_next;
            cyc_reg <= cyc_next;
            nop_left_reg <= nop_left_next;
        end
    end

    // q1 decode: latch instruction and its class
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            ir_reg <= 16'h0000;
            {isz_r, isnz_r, mlit_r, mreg_r, bnz_r, dest_r} <= 6'h00;
            addr_reg <= 12'h000;
            pc_reg <= PC_WIDTH'(exec_pkg::PC_RESET);
            zero_reg <= 1'b0;
            two_word_reg <= 1'b0;
        end else if (CE_I && phase_reg == exec_pkg::PH_DECODE) begin
            ir_reg <= INSTR_I;
            // a nop cycle decodes nothing, so the fetched word is dropped
            isz_r <= accept && is_isz;
            isnz_r <= accept && is_isnz;
            mlit_r <= accept && is_mlit;
            mreg_r <= accept && is_mreg;
            bnz_r <= accept && is_bnz;
            dest_r <= dest_file;
            addr_reg <= addr;
            pc_reg <= PC_I;
            zero_reg <= ZERO_FLAG_I;
            two_word_reg <= NEXT_TWO_WORD_I;
        end
    end

    // q2 read operand, q3 process
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            operand_reg <= exec_pkg::BYTE_RESET;
            result_reg <= exec_pkg::BYTE_RESET;
            prod_reg <= 16'h0000;
        end else if (CE_I && phase_reg == exec_pkg::PH_READ) begin
            operand_reg <= FILE_RDATA_I;
        end else if (CE_I && phase_reg == exec_pkg::PH_PROCESS) begin
            result_reg <= incr_val;
            prod_reg <= prod;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    wire logic wr_ph = CE_I && phase_reg == exec_pkg::PH_PROCESS;
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            FILE_ADDR_O <= 12'h000;
            FILE_RD_O <= 1'b0;
            FILE_WR_O <= 1'b0;
            FILE_WDATA_O <= exec_pkg::BYTE_RESET;
            ACC_WR_O <= 1'b0;
            ACC_WDATA_O <= exec_pkg::BYTE_RESET;
            PROD_WR_O <= 1'b0;
            PROD_HIGH_O <= exec_pkg::BYTE_RESET;
            PROD_LOW_O <= exec_pkg::BYTE_RESET;
            PC_LOAD_O <= 1'b0;
            PC_NEXT_O <= PC_WIDTH'(exec_pkg::PC_RESET);
            FLUSH_O <= 1'b0;
            BUSY_O <= 1'b0;
            PHASE_O <= exec_pkg::PH_DECODE;
        end else if (CE_I) begin
            PHASE_O <= phase_next;
            BUSY_O <= cyc_next == exec_pkg::CYC_NOP;
            // read strobe during q2 for file-operand instructions
            FILE_ADDR_O <= (phase_reg == exec_pkg::PH_DECODE) ?
                addr : addr_reg;
            FILE_RD_O <= phase_reg == exec_pkg::PH_DECODE && accept &&
                (is_isz || is_isnz || is_mreg);
            // q4 writes; multiply never writes file or accumulator
            FILE_WR_O <= wr_ph && incr_op && dest_r;
            ACC_WR_O <= wr_ph && incr_op && !dest_r;
            FILE_WDATA_O <= incr_val;
            ACC_WDATA_O <= incr_val;
            PROD_WR_O <= wr_ph && (mlit_r || mreg_r);
            if (wr_ph && (mlit_r || mreg_r)) begin
                PROD_HIGH_O <= prod[15:8];
                PROD_LOW_O <= prod[7:0];
            end
            PC_LOAD_O <= wr_ph && taken;
            PC_NEXT_O <= br_target;
            // flush marks the discarded prefetch at the end of q4
            FLUSH_O <= CE_I && phase_reg == exec_pkg::PH_WRITE &&
                cyc_reg == exec_pkg::CYC_EXEC && (do_skip || taken);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_skip_end;
        phase_reg == exec_pkg::PH_WRITE && cyc_reg == exec_pkg::CYC_EXEC
            && do_skip && !two_word_reg && CE_I;
    endsequence
    a_skip_one_nop: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        s_skip_end |=> cyc_reg == exec_pkg::CYC_NOP)
        else $error("skip did not enter a nop cycle");
    sequence s_skip_two;
        phase_reg == exec_pkg::PH_WRITE && cyc_reg == exec_pkg::CYC_EXEC
            && do_skip && two_word_reg && CE_I;
    endsequence
    a_skip_two_word: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        s_skip_two |=> cyc_reg == exec_pkg::CYC_NOP
            && nop_left_reg == 2'd1)
        else $error("two-word skip lacks second nop");
    a_nonzero_skip: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (isnz_r && phase_reg == exec_pkg::PH_WRITE
            && cyc_reg == exec_pkg::CYC_EXEC && CE_I && !res_zero)
        |=> FLUSH_O && BUSY_O)
        else $error("nonzero result did not skip");
    a_mult_no_acc: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        PROD_WR_O |-> !ACC_WR_O && !FILE_WR_O)
        else $error("multiply disturbed accumulator or file");
    a_mult_product: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        PROD_WR_O |-> {PROD_HIGH_O, PROD_LOW_O} == prod_reg)
        else $error("product pair mismatch");
    a_branch_load: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        PC_LOAD_O |-> PHASE_O == exec_pkg::PH_WRITE
            && PC_NEXT_O == $past(br_target))
        else $error("branch load wrong phase or target");
    a_branch_zero: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        PC_LOAD_O |-> !$past(zero_reg))
        else $error("branch taken with zero set");
    a_phase_walk: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (CE_I && phase_reg == exec_pkg::PH_DECODE)
        |=> phase_reg == exec_pkg::PH_READ)
        else $error("phase did not advance");
    // a branch that loads the counter owes one no-op cycle afterwards
    sequence s_branch_taken;
        phase_reg == exec_pkg::PH_WRITE && cyc_reg == exec_pkg::CYC_EXEC
            && taken && CE_I;
    endsequence
    a_branch_nop: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        s_branch_taken |=> cyc_reg == exec_pkg::CYC_NOP
            && nop_left_reg == 2'd0 && BUSY_O)
        else $error("taken branch lacks its no-op cycle");
    a_read_phase: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        FILE_RD_O |-> PHASE_O == exec_pkg::PH_READ)
        else $error("file read outside phase two");
    a_write_phase: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (FILE_WR_O || ACC_WR_O || PROD_WR_O)
        |-> PHASE_O == exec_pkg::PH_WRITE)
        else $error("write outside phase four");
    a_nop_quiet: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (cyc_reg == exec_pkg::CYC_NOP && phase_reg == exec_pkg::PH_WRITE)
        |-> !FILE_WR_O && !ACC_WR_O && !PROD_WR_O && !PC_LOAD_O)
        else $error("no-op cycle wrote a result");
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the increment-skip, multiply and branch slice
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic valid_i = 1'b0;
    logic two_word_i = 1'b0;
    logic [20:0] pc_i = 21'h000100;
    logic [7:0] acc_i = 8'h00;
    logic [3:0] bank_sel_i = 4'h3;
    logic zero_i = 1'b0;
    logic ext_i = 1'b0;
    logic [11:0] index_base_i = 12'h200;
    logic [7:0] rdata_i = 8'h00;
    logic [11:0] file_addr;
    logic file_rd, file_wr, acc_wr, prod_wr, pc_load, flush, busy;
    logic [7:0] file_wdata, acc_wdata, prod_high, prod_low;
    logic [20:0] pc_next;
    logic [3:0] phase;
    int miscompares = 0;
    int n_checks = 0;

    // one row: inputs, then expected address, writes {prod,pc,file,acc},
    // written byte, product, new counter and count of no-op cycles
    typedef struct {
        logic [15:0] instr;
        logic [7:0] acc, rdata;
        logic zf, ext, two;
        logic [11:0] addr;
        logic rd;
        logic [3:0] wr;
        logic [7:0] data;
        logic [15:0] prod;
        logic [20:0] pc;
        int nops;
    } row_t;
    row_t rows[$];

    always #10 clock_i = ~clock_i;

    incr_skip_multiply_branch_exec DUT (
        .CLOCK_I(clock_i), .SRST_I(srst_i), .CE_I(ce_i),
        .INSTR_I(instr_i), .INSTR_VALID_I(valid_i),
        .NEXT_TWO_WORD_I(two_word_i), .PC_I(pc_i), .ACC_I(acc_i),
        .BANK_SEL_I(bank_sel_i), .ZERO_FLAG_I(zero_i), .EXT_SET_I(ext_i),
        .INDEX_BASE_I(index_base_i), .FILE_RDATA_I(rdata_i),
        .FILE_ADDR_O(file_addr), .FILE_RD_O(file_rd), .FILE_WR_O(file_wr),
        .FILE_WDATA_O(file_wdata), .ACC_WR_O(acc_wr),
        .ACC_WDATA_O(acc_wdata), .PROD_WR_O(prod_wr),
        .PROD_HIGH_O(prod_high), .PROD_LOW_O(prod_low),
        .PC_LOAD_O(pc_load), .PC_NEXT_O(pc_next), .FLUSH_O(flush),
        .BUSY_O(busy), .PHASE_O(phase)
    );

    // ----------------------------------------
    // compare, timing and closing tasks
    // ----------------------------------------
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask

    task automatic chk_vec(input string what, input logic [20:0] e,
                           input logic [20:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock_i);
            #1;
        end
    endtask

    task print_verdict;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang costs at most a few thousand cycles
    initial begin
        #100000;
        miscompares++;
        print_verdict;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int c;
        rows.push_back('{16'h3f45, 8'h00, 8'hff, 0, 0, 0, 12'h345, 1, 4'h2,
                         8'h00, 16'h0, 21'h0, 1});
        rows.push_back('{16'h3f45, 8'h00, 8'hff, 0, 0, 1, 12'h345, 1, 4'h2,
                         8'h00, 16'h0, 21'h0, 2});
        rows.push_back('{16'h3c90, 8'h00, 8'h10, 0, 0, 0, 12'hf90, 1, 4'h1,
                         8'h11, 16'h0, 21'h0, 0});
        rows.push_back('{16'h4a20, 8'h00, 8'h05, 0, 0, 0, 12'h020, 1, 4'h2,
                         8'h06, 16'h0, 21'h0, 1});
        rows.push_back('{16'h485f, 8'h00, 8'hff, 0, 1, 0, 12'h25f, 1, 4'h1,
                         8'h00, 16'h0, 21'h0, 0});
        rows.push_back('{16'h4860, 8'h00, 8'h7f, 0, 1, 1, 12'h060, 1, 4'h1,
                         8'h80, 16'h0, 21'h0, 2});
        rows.push_back('{16'h0dc4, 8'he2, 8'h00, 0, 0, 0, 12'h000, 0, 4'h8,
                         8'h00, 16'had08, 21'h0, 0});
        rows.push_back('{16'h0d00, 8'h55, 8'h00, 0, 0, 0, 12'h000, 0, 4'h8,
                         8'h00, 16'h0000, 21'h0, 0});
        rows.push_back('{16'h0dff, 8'hff, 8'h00, 0, 0, 0, 12'h000, 0, 4'h8,
                         8'h00, 16'hfe01, 21'h0, 0});
        rows.push_back('{16'h03b5, 8'hc4, 8'hb5, 0, 0, 0, 12'h3b5, 1, 4'h8,
                         8'h00, 16'h8a94, 21'h0, 0});
        rows.push_back('{16'h0210, 8'h03, 8'h77, 0, 1, 0, 12'h210, 1, 4'h8,
                         8'h00, 16'h0165, 21'h0, 0});
        rows.push_back('{16'he110, 8'h00, 8'h00, 0, 0, 0, 12'h000, 0, 4'h4,
                         8'h00, 16'h0, 21'h000120, 1});
        rows.push_back('{16'he180, 8'h00, 8'h00, 0, 0, 0, 12'h000, 0, 4'h4,
                         8'h00, 16'h0, 21'h000000, 1});
        rows.push_back('{16'he17f, 8'h00, 8'h00, 1, 0, 0, 12'h000, 0, 4'h0,
                         8'h00, 16'h0, 21'h0, 0});
        rows.push_back('{16'he17f, 8'h00, 8'h00, 0, 0, 0, 12'h000, 0, 4'h4,
                         8'h00, 16'h0, 21'h0001fe, 1});
        // reset held six cycles, outputs cleared
        step(6);
        srst_i = 1'b0;
        chk_vec("phase", 21'h1, {17'h0, phase});
        chk_vec("product", 21'h0, {5'h0, prod_high, prod_low});
        chk_bit("busy", 1'b0, busy);
        foreach (rows[i]) begin
            // present the row in phase one
            c = 0;
            while (phase !== 4'b0001 && c < 20) begin
                step(1);
                c++;
            end
            instr_i = rows[i].instr;
            acc_i = rows[i].acc;
            rdata_i = rows[i].rdata;
            zero_i = rows[i].zf;
            ext_i = rows[i].ext;
            two_word_i = rows[i].two;
            valid_i = 1'b1;
            step(1);
            chk_vec("phase", 21'h2, {17'h0, phase});
            chk_bit("file read", rows[i].rd, file_rd);
            if (rows[i].rd) begin
                chk_vec("address", 21'(rows[i].addr),
                        21'(file_addr));
            end
            step(2);
            chk_vec("phase", 21'h8, {17'h0, phase});
            chk_bit("prod write", rows[i].wr[3], prod_wr);
            chk_bit("pc load", rows[i].wr[2], pc_load);
            chk_bit("file write", rows[i].wr[1], file_wr);
            chk_bit("acc write", rows[i].wr[0], acc_wr);
            if (rows[i].wr[1]) begin
                chk_vec("file data", 21'(rows[i].data),
                        21'(file_wdata));
            end
            if (rows[i].wr[0]) begin
                chk_vec("acc data", 21'(rows[i].data),
                        21'(acc_wdata));
            end
            if (rows[i].wr[3]) begin
                chk_vec("product", 21'(rows[i].prod),
                        {5'h0, prod_high, prod_low});
            end
            if (rows[i].wr[2]) begin
                chk_vec("new pc", rows[i].pc, pc_next);
            end
            // a marker multiply waits out the no-op cycles
            instr_i = 16'h0d03;
            acc_i = 8'h05;
            c = 0;
            do begin
                step(1);
                c++;
                if (c == 1) begin
                    chk_bit("flush", rows[i].nops != 0, flush);
                    chk_bit("busy", rows[i].nops != 0, busy);
                end
            end while (prod_wr !== 1'b1 && c < 20);
            chk_vec("marker delay", 21'(4 * (rows[i].nops + 1)),
                    21'(c));
            chk_vec("marker", 21'h00000f,
                    {5'h0, prod_high, prod_low});
        end
        // enable low freezes an instruction in phase two
        step(1);
        instr_i = 16'h0d11;
        acc_i = 8'h02;
        step(1);
        ce_i = 1'b0;
        step(5);
        chk_vec("frozen phase", 21'h2, {17'h0, phase});
        chk_bit("frozen write", 1'b0, prod_wr);
        ce_i = 1'b1;
        valid_i = 1'b0;
        step(2);
        chk_bit("prod write", 1'b1, prod_wr);
        chk_vec("product", 21'h000022,
                {5'h0, prod_high, prod_low});
        // reset in mid-instruction drops the pending write
        valid_i = 1'b1;
        step(2);
        srst_i = 1'b1;
        valid_i = 1'b0;
        step(1);
        srst_i = 1'b0;
        chk_vec("phase", 21'h1, {17'h0, phase});
        step(4);
        chk_bit("prod write", 1'b0, prod_wr);
        chk_vec("product", 21'h0, {5'h0, prod_high, prod_low});
        print_verdict;
    end
endmodule
